// ### hdl/plb_logic_block.v
// configurable logic block: term arrays, clocking, output enables, wishbone config
`timescale 1ns/10ps
`include "plb_logic_map.vh"

module plb_logic_block #(
  parameter N_IN  = 36,
  parameter N_MC  = 16,
  parameter N_PAL = 5,
  parameter N_PLA = 32,
  parameter N_CT  = 6,
  parameter N_GCK = 4
) (
  // clock and reset
  input  wire                    clk_i,
  input  wire                    rst_i,
  // classic wishbone slave
  input  wire                    wb_cyc_i,
  input  wire                    wb_stb_i,
  input  wire                    wb_we_i,
  input  wire [`PLB_ADDR_W-1:0]  wb_adr_i,
  input  wire [3:0]              wb_sel_i,
  input  wire [31:0]             wb_dat_i,
  output wire [31:0]             wb_dat_o,
  output wire                    wb_ack_o,
  // routing matrix side
  input  wire [N_IN-1:0]         routing_matrix_i,
  output wire [2*N_MC-1:0]       routing_matrix_fb_o,
  // global pins
  input  wire [N_GCK-1:0]        global_clock_i,
  input  wire                    global_three_state_pin_i,
  // macrocell i/o pins
  input  wire [N_MC-1:0]         pin_i,
  output wire [N_MC-1:0]         pin_o,
  output wire [N_MC-1:0]         pin_oe_o
);

  localparam N_TERM  = N_MC * N_PAL + N_PLA + N_CT;
  localparam PLA_BAS = N_MC * N_PAL;
  localparam CT_BAS  = PLA_BAS + N_PLA;
  localparam N_SYNC  = N_MC + N_GCK + 1;
  localparam HI_W    = N_IN - `PLB_LO_W;

  // a literal set in both masks makes the term false: the unprogrammed state
  function term_and;
    input [N_IN-1:0] in_v;
    input [N_IN-1:0] tm;
    input [N_IN-1:0] cm;
    begin
      term_and = &((in_v | ~tm) & (~in_v | ~cm));
    end
  endfunction

  function term_or;
    input [N_IN-1:0] in_v;
    input [N_IN-1:0] tm;
    input [N_IN-1:0] cm;
    begin
      term_or = |((in_v & tm) | (~in_v & cm));
    end
  endfunction

  // configuration storage
  reg  [N_IN-1:0]         term_true [0:N_TERM-1];
  reg  [N_IN-1:0]         term_comp [0:N_TERM-1];
  reg  [`PLB_MC_W-1:0]    mc_cfg    [0:N_MC-1];
  reg  [N_PLA-1:0]        or_mask   [0:N_MC-1];
  reg  [`PLB_CTRL_W-1:0]  ctrl_reg;
  reg  [6:0]              term_sel_reg;

  // bus registers
  reg                     ack_reg;
  reg  [31:0]             dat_reg;
  reg  [31:0]             dat_next;

  // pin synchronisers and filtered levels
  reg  [N_SYNC-1:0]       sy1_reg;
  reg  [N_SYNC-1:0]       sy2_reg;
  reg  [N_SYNC-1:0]       sy3_reg;
  reg  [N_SYNC-1:0]       lvl_reg;

  // edge tracking
  reg  [N_GCK-1:0]        gclk_prev_reg;
  reg  [1:0]              ctclk_prev_reg;

  // output flops
  reg  [N_MC-1:0]         pin_o_reg;
  reg  [N_MC-1:0]         pin_oe_reg;
  reg  [2*N_MC-1:0]       fb_reg;

  wire [N_TERM-1:0]       pterm;
  wire [N_CT-1:0]         cterm;
  wire [N_MC-1:0]         mc_result;
  wire [N_MC-1:0]         mc_oe;
  wire [N_GCK-1:0]        gclk_lvl;
  wire [N_GCK-1:0]        gclk_rise;
  wire [N_GCK-1:0]        gclk_fall;
  wire [1:0]              ctclk_rise;
  wire [N_MC-1:0]         pin_lvl;
  wire                    gts_lvl;
  wire                    req;
  wire [`PLB_OFF_IDX_W-1:0] idx;
  wire [N_IN-1:0]         sel_true;
  wire [N_IN-1:0]         sel_comp;
  wire [31:0]             status_w;
  integer                 k;

  assign pin_lvl = lvl_reg[N_MC-1:0];
  assign gts_lvl = lvl_reg[N_SYNC-1];

  // ---------------- product and control terms ----------------
  genvar t;
  generate
    for (t = 0; t < N_TERM; t = t + 1) begin : g_term
      assign pterm[t] = term_and(routing_matrix_i, term_true[t], term_comp[t]);
    end
    for (t = 0; t < N_CT; t = t + 1) begin : g_ct
      // each control term is product or sum independently
      assign cterm[t] = ctrl_reg[`PLB_CTRL_CT_SUM_LSB + t] ?
                        term_or(routing_matrix_i, term_true[CT_BAS + t],
                                term_comp[CT_BAS + t]) :
                        pterm[CT_BAS + t];
    end
  endgenerate

  // ---------------- global clocks ----------------
  // clock zero always follows its pin; the others may follow a macrocell
  assign gclk_lvl[0] = lvl_reg[N_MC];
  generate
    for (t = 1; t < N_GCK; t = t + 1) begin : g_gclk
      wire [3:0] src;
      assign src = ctrl_reg[`PLB_CTRL_GSRC_LSB + 4*(t-1) +: 4];
      assign gclk_lvl[t] = ctrl_reg[`PLB_CTRL_GASYNC_LSB + t - 1] ?
                           mc_result[src] : lvl_reg[N_MC + t];
    end
  endgenerate

  // edges compare with last cycle's level, so each level must stand a full cycle
  assign gclk_rise  = gclk_lvl & ~gclk_prev_reg;
  assign gclk_fall  = ~gclk_lvl & gclk_prev_reg;
  assign ctclk_rise = {cterm[`PLB_CT_CLK_B], cterm[`PLB_CT_CLK_A]} & ~ctclk_prev_reg;

  // ---------------- macrocells ----------------
  generate
    for (t = 0; t < N_MC; t = t + 1) begin : g_mc
      wire [`PLB_MC_W-1:0] cfg;
      wire                 pal_sum;
      wire                 pla_sum;
      wire [2:0]           csel;
      wire [2:0]           osel;
      reg                  cap;
      reg                  oe;

      assign cfg  = mc_cfg[t];
      assign csel = cfg[`PLB_MC_CLK_LSB +: 3];
      assign osel = cfg[`PLB_MC_OE_LSB +: 3];
      assign pal_sum = |pterm[t*N_PAL +: N_PAL];
      // shared pool terms may be summed into any number of macrocells
      assign pla_sum = |(pterm[PLA_BAS +: N_PLA] & or_mask[t]);

      always @* begin
        case (csel)
          `PLB_CLK_CT2: begin
            cap = ctclk_rise[0];
          end
          `PLB_CLK_CT3: begin
            cap = ctclk_rise[1];
          end
          default: begin
            if (csel[2]) begin
              cap = 1'b0;
            end else begin
              cap = cfg[`PLB_MC_FALL] ? gclk_fall[csel[1:0]] :
                                        gclk_rise[csel[1:0]];
            end
          end
        endcase
      end

      always @* begin
        case (osel)
          `PLB_OE_OFF: begin
            oe = 1'b0;
          end
          `PLB_OE_ON: begin
            oe = 1'b1;
          end
          default: begin
            if (osel < `PLB_OE_CT_BASE + 3'h4) begin
              oe = cterm[osel];
            end else begin
              oe = 1'b0;
            end
          end
        endcase
      end

      // disabled global three-state pin has no effect
      assign mc_oe[t] = oe & ~(ctrl_reg[`PLB_CTRL_GTS_EN] & ~gts_lvl);

      plb_macrocell u_mc (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .sum_i    (pal_sum | pla_sum),
        .mode_i   (cfg[`PLB_MC_MODE_LSB +: 2]),
        .cap_i    (cap),
        .preset_i (cterm[`PLB_CT_PRESET]),
        .clear_i  (cterm[`PLB_CT_CLEAR]),
        .pr_en_i  (cfg[`PLB_MC_PR_EN]),
        .q_o      (),
        .result_o (mc_result[t])
      );
    end
  endgenerate

  // ---------------- pins, feedback, edge history ----------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      sy1_reg        <= {N_SYNC{1'b0}};
      sy2_reg        <= {N_SYNC{1'b0}};
      sy3_reg        <= {N_SYNC{1'b0}};
      lvl_reg        <= {N_SYNC{1'b0}};
      gclk_prev_reg  <= {N_GCK{1'b0}};
      ctclk_prev_reg <= 2'h0;
      pin_o_reg      <= {N_MC{1'b0}};
      pin_oe_reg     <= {N_MC{1'b0}};
      fb_reg         <= {2*N_MC{1'b0}};
    end else begin
      sy1_reg <= {global_three_state_pin_i, global_clock_i, pin_i};
      sy2_reg <= sy1_reg;
      sy3_reg <= sy2_reg;
      // a level is taken only once the two later stages agree
      lvl_reg <= (sy2_reg & sy3_reg) | (lvl_reg & (sy2_reg | sy3_reg));
      gclk_prev_reg  <= gclk_lvl;
      ctclk_prev_reg <= {cterm[`PLB_CT_CLK_B], cterm[`PLB_CT_CLK_A]};
      pin_o_reg      <= mc_result;
      pin_oe_reg     <= mc_oe;
      fb_reg         <= {pin_lvl, mc_result};
    end
  end

  assign pin_o               = pin_o_reg;
  assign pin_oe_o            = pin_oe_reg;
  assign routing_matrix_fb_o = fb_reg;

  // ---------------- wishbone slave ----------------
  assign req      = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign idx      = wb_adr_i[`PLB_OFF_IDX_LSB +: `PLB_OFF_IDX_W];
  // a select beyond the last term reads zero, never an unknown
  assign sel_true = (term_sel_reg < N_TERM) ? term_true[term_sel_reg] : {N_IN{1'b0}};
  assign sel_comp = (term_sel_reg < N_TERM) ? term_comp[term_sel_reg] : {N_IN{1'b0}};
  assign status_w = {{(32-N_MC-N_GCK-1){1'b0}}, gts_lvl, gclk_lvl, mc_result};

  always @* begin
    dat_next = 32'h0000_0000;
    if (wb_adr_i == `PLB_OFF_CTRL) begin
      dat_next[`PLB_CTRL_W-1:0] = ctrl_reg;
    end else if (wb_adr_i == `PLB_OFF_TERM_SEL) begin
      dat_next[6:0] = term_sel_reg;
    end else if (wb_adr_i == `PLB_OFF_TRUE_LO) begin
      dat_next = sel_true[`PLB_LO_W-1:0];
    end else if (wb_adr_i == `PLB_OFF_COMP_LO) begin
      dat_next = sel_comp[`PLB_LO_W-1:0];
    end else if (wb_adr_i == `PLB_OFF_TERM_HI) begin
      dat_next[HI_W-1:0] = sel_true[N_IN-1:`PLB_LO_W];
      dat_next[`PLB_HI_COMP_LSB +: HI_W] = sel_comp[N_IN-1:`PLB_LO_W];
    end else if (wb_adr_i == `PLB_OFF_STATUS) begin
      dat_next = status_w;
    end else if ((wb_adr_i & ~`PLB_OFF_IDX_MASK) == `PLB_OFF_MC_BASE) begin
      dat_next[`PLB_MC_W-1:0] = mc_cfg[idx];
    end else if ((wb_adr_i & ~`PLB_OFF_IDX_MASK) == `PLB_OFF_OR_BASE) begin
      dat_next[N_PLA-1:0] = or_mask[idx];
    end
  end

  // writes take whole words; byte lanes are honoured only for all-lanes writes
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg      <= 1'b0;
      dat_reg      <= 32'h0000_0000;
      ctrl_reg     <= {`PLB_CTRL_W{1'b0}};
      term_sel_reg <= 7'h00;
      for (k = 0; k < N_TERM; k = k + 1) begin
        term_true[k] <= {N_IN{1'b1}};
        term_comp[k] <= {N_IN{1'b1}};
      end
      for (k = 0; k < N_MC; k = k + 1) begin
        mc_cfg[k]  <= {`PLB_MC_W{1'b0}};
        or_mask[k] <= {N_PLA{1'b0}};
      end
    end else begin
      ack_reg <= req;
      dat_reg <= req ? dat_next : 32'h0000_0000;
      if (req && wb_we_i && (wb_sel_i == 4'hF)) begin
        if (wb_adr_i == `PLB_OFF_CTRL) begin
          ctrl_reg <= wb_dat_i[`PLB_CTRL_W-1:0];
        end else if (wb_adr_i == `PLB_OFF_TERM_SEL) begin
          term_sel_reg <= wb_dat_i[6:0];
        end else if (term_sel_reg < N_TERM) begin
          if (wb_adr_i == `PLB_OFF_TRUE_LO) begin
            term_true[term_sel_reg][`PLB_LO_W-1:0] <= wb_dat_i;
          end else if (wb_adr_i == `PLB_OFF_COMP_LO) begin
            term_comp[term_sel_reg][`PLB_LO_W-1:0] <= wb_dat_i;
          end else if (wb_adr_i == `PLB_OFF_TERM_HI) begin
            term_true[term_sel_reg][N_IN-1:`PLB_LO_W] <= wb_dat_i[HI_W-1:0];
            term_comp[term_sel_reg][N_IN-1:`PLB_LO_W] <=
              wb_dat_i[`PLB_HI_COMP_LSB +: HI_W];
          end
        end
        // one index field selects the macrocell in both tables
        if ((wb_adr_i & ~`PLB_OFF_IDX_MASK) == `PLB_OFF_MC_BASE) begin
          mc_cfg[idx] <= wb_dat_i[`PLB_MC_W-1:0];
        end else if ((wb_adr_i & ~`PLB_OFF_IDX_MASK) == `PLB_OFF_OR_BASE) begin
          or_mask[idx] <= wb_dat_i[N_PLA-1:0];
        end
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

endmodule // plb_logic_block

// ### hdl/plb_logic_map.vh
// register offsets, field layout and codes of the logic block
`ifndef PLB_LOGIC_MAP_VH
`define PLB_LOGIC_MAP_VH

// wishbone word offsets (byte addresses)
`define PLB_ADDR_W        8
`define PLB_OFF_CTRL      8'h00
`define PLB_OFF_TERM_SEL  8'h04
`define PLB_OFF_TRUE_LO   8'h08
`define PLB_OFF_COMP_LO   8'h0C
`define PLB_OFF_TERM_HI   8'h10
`define PLB_OFF_STATUS    8'h14
`define PLB_OFF_MC_BASE   8'h40
`define PLB_OFF_OR_BASE   8'h80
`define PLB_OFF_IDX_LSB   2
`define PLB_OFF_IDX_W     4
`define PLB_OFF_IDX_MASK  8'h3C

// control register fields
`define PLB_CTRL_CT_SUM_LSB  0
`define PLB_CTRL_GTS_EN      6
`define PLB_CTRL_GASYNC_LSB  7
`define PLB_CTRL_GSRC_LSB    10
`define PLB_CTRL_W           22

// term high word: upper bits of true mask, then of complement mask
`define PLB_LO_W          32
`define PLB_HI_COMP_LSB   4

// macrocell configuration word fields
`define PLB_MC_MODE_LSB   0
`define PLB_MC_CLK_LSB    2
`define PLB_MC_FALL       5
`define PLB_MC_OE_LSB     6
`define PLB_MC_PR_EN      9
`define PLB_MC_W          10

// storage modes
`define PLB_MODE_D        2'h0
`define PLB_MODE_T        2'h1
`define PLB_MODE_COMB     2'h2

// clock sources
`define PLB_CLK_CT2       3'h4
`define PLB_CLK_CT3       3'h5

// output enable sources
`define PLB_OE_OFF        3'h0
`define PLB_OE_ON         3'h1
`define PLB_OE_CT_BASE    3'h2

// control term numbers
`define PLB_CT_CLEAR      0
`define PLB_CT_PRESET     1
`define PLB_CT_CLK_A      2
`define PLB_CT_CLK_B      3

`endif

// ### hdl/plb_macrocell.v
// one macrocell: d, t or combinational storage with preset and clear
`timescale 1ns/10ps
`include "plb_logic_map.vh"

module plb_macrocell (
  // clock and power-up reset
  input  wire       clk_i,
  input  wire       rst_i,
  // logic and configuration
  input  wire       sum_i,
  input  wire [1:0] mode_i,
  input  wire       cap_i,
  input  wire       preset_i,
  input  wire       clear_i,
  input  wire       pr_en_i,
  // results
  output wire       q_o,
  output wire       result_o
);

  reg q_reg;

  always @(posedge clk_i) begin
    if (rst_i) begin
      q_reg <= 1'b0;
    end else if (pr_en_i && clear_i) begin
      q_reg <= 1'b0;
    end else if (pr_en_i && preset_i) begin
      q_reg <= 1'b1;
    end else if (cap_i) begin
      case (mode_i)
        `PLB_MODE_D: begin
          q_reg <= sum_i;
        end
        `PLB_MODE_T: begin
          q_reg <= q_reg ^ sum_i;
        end
        default: begin
          q_reg <= q_reg;
        end
      endcase
    end
  end

  assign q_o      = q_reg;
  // combinational mode bypasses the storage element
  assign result_o = (mode_i == `PLB_MODE_COMB) ? sum_i : q_reg;

endmodule // plb_macrocell

// ### test/plb_logic_block_checker.sv
// port assertions for the configurable logic block
`timescale 1ns/10ps
`include "plb_logic_map.vh"

module plb_logic_block_checker #(
  parameter N_MC = 16
) (
  // clock and reset
  input wire                    clk_i,
  input wire                    rst_i,
  // wishbone
  input wire                    wb_cyc_i,
  input wire                    wb_stb_i,
  input wire                    wb_we_i,
  input wire [`PLB_ADDR_W-1:0]  wb_adr_i,
  input wire [3:0]              wb_sel_i,
  input wire [31:0]             wb_dat_i,
  input wire [31:0]             wb_dat_o,
  input wire                    wb_ack_o,
  // pins and feedback
  input wire [2*N_MC-1:0]       routing_matrix_fb_o,
  input wire                    global_three_state_pin_i,
  input wire [N_MC-1:0]         pin_i,
  input wire [N_MC-1:0]         pin_o,
  input wire [N_MC-1:0]         pin_oe_o
);
  logic gts_en_reg;
  wire  take = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // shadow of the three-state enable, seen only through bus writes
  always @(posedge clk_i)
    if (rst_i)
      gts_en_reg <= 1'b0;
    else if (take && wb_we_i && wb_sel_i == 4'hF && wb_adr_i == `PLB_OFF_CTRL)
      gts_en_reg <= wb_dat_i[`PLB_CTRL_GTS_EN];

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // eight cycles covers the pin synchroniser, filter and output flop
  sequence s_gts_low;
    (gts_en_reg && !global_three_state_pin_i) [*8];
  endsequence
  sequence s_pin_still;
    (pin_i == $past(pin_i)) [*8];
  endsequence

  a_reset_clear: assert property ($fell(rst_i) |-> {routing_matrix_fb_o, pin_o, pin_oe_o} == '0)
    else $error("outputs not cleared by reset");
  a_fb_result: assert property (routing_matrix_fb_o[N_MC-1:0] == pin_o)
    else $error("macrocell feedback differs from result");
  a_gts_off: assert property (s_gts_low |-> pin_oe_o == '0)
    else $error("output driven while three-state pin low");
  a_pin_fb: assert property (s_pin_still |-> routing_matrix_fb_o[2*N_MC-1:N_MC] == pin_i)
    else $error("pin feedback does not follow pin");
  a_ack_next: assert property (take |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i &&
    (wb_adr_i inside {[8'h18:8'h3F], [8'hC0:8'hFF]}) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule // plb_logic_block_checker

bind plb_logic_block plb_logic_block_checker #(.N_MC(N_MC)) u_checker (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .routing_matrix_fb_o(routing_matrix_fb_o),
  .global_three_state_pin_i(global_three_state_pin_i), .pin_i(pin_i), .pin_o(pin_o),
  .pin_oe_o(pin_oe_o)
);

// ### test/plb_logic_block_test.sv
// self-checking bench for the configurable logic block
`timescale 1ns/10ps
`include "plb_logic_map.vh"

module plb_logic_block_test;
  localparam logic [7:0] MC3 = `PLB_OFF_MC_BASE + 8'h0C;
  localparam logic [7:0] MC4 = `PLB_OFF_MC_BASE + 8'h10;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [35:0] rmx = 36'h0;
  logic [3:0]  gclk = 4'h0;
  logic        global_three_state_pin = 1'b1;
  logic [15:0] pin = 16'h0;
  wire  [31:0] rdat;
  wire         ack;
  wire  [31:0] fb;
  wire  [15:0] pout;
  wire  [15:0] poe;
  logic [31:0] q;
  integer      i;
  integer      fails = 0;
  integer      checked = 0;
  // routing inputs beside expected results of macrocells 2..0
  logic [38:0] rows [0:5] = '{{36'h0, 3'h0}, {36'h1, 3'h1}, {36'h100, 3'h1},
                              {36'h2, 3'h6}, {36'h82, 3'h0}, {36'h3, 3'h7}};

  plb_logic_block u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .routing_matrix_i(rmx), .routing_matrix_fb_o(fb), .global_clock_i(gclk),
    .global_three_state_pin_i(global_three_state_pin), .pin_i(pin), .pin_o(pout), .pin_oe_o(poe)
  );

  always #4 clk_i = ~clk_i;

  task automatic tick(input integer n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    chk(ack, 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic term(input logic [6:0] t, input logic [35:0] tm, input logic [35:0] cm);
    wb(1'b1, `PLB_OFF_TERM_SEL, {25'h0, t});
    wb(1'b1, `PLB_OFF_TRUE_LO, tm[31:0]);
    wb(1'b1, `PLB_OFF_COMP_LO, cm[31:0]);
    wb(1'b1, `PLB_OFF_TERM_HI, {24'h0, cm[35:32], tm[35:32]});
  endtask

  // pin clock is filtered, so each level is held well past the filter
  task automatic gedge(input logic v);
    gclk[0] <= v;
    tick(8);
  endtask

  task automatic oe4(input logic [35:0] r, input logic e);
    rmx <= r;
    tick(2);
    chk(poe[4], e);
  endtask

  task automatic mcs(input logic [35:0] r, input integer b, input logic e);
    rmx <= r;
    tick(3);
    chk(pout[b], e);
  endtask

  task automatic close_out();
    if (fails == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    tick(4);
    rst_i <= 1'b0;
    tick(1);
    chk({fb, poe, pout}, 64'h0);
    wb(1'b0, `PLB_OFF_MC_BASE, 32'h0);
    chk(q, 32'h0);
    term(7'd0, 36'h1, 36'h0);
    term(7'd4, 36'h100, 36'h0);
    term(7'd80, 36'h2, 36'h80);
    wb(1'b1, `PLB_OFF_OR_BASE + 8'h04, 32'h1);
    wb(1'b1, `PLB_OFF_OR_BASE + 8'h08, 32'h1);
    for (i = 0; i < 3; i++)
      wb(1'b1, `PLB_OFF_MC_BASE + 8'(4 * i), 32'h042);
    for (i = 0; i < 6; i++) begin
      rmx <= rows[i][38:3];
      tick(2);
      chk(pout[2:0], rows[i][2:0]);
    end
    chk(poe[2:0], 3'h7);
    term(7'd15, 36'h4, 36'h0);
    wb(1'b1, MC3, 32'h040);
    rmx <= 36'h4;
    gedge(1'b1);
    chk(pout[3], 1'b1);
    rmx <= 36'h0;
    gedge(1'b0);
    chk(pout[3], 1'b1);
    gedge(1'b1);
    chk(pout[3], 1'b0);
    wb(1'b1, MC3, 32'h060);
    rmx <= 36'h4;
    gedge(1'b0);
    chk(pout[3], 1'b1);
    rmx <= 36'h0;
    gedge(1'b1);
    chk(pout[3], 1'b1);
    wb(1'b1, MC3, 32'h041);
    rmx <= 36'h4;
    for (i = 0; i < 3; i++) begin
      gedge(1'b0);
      gedge(1'b1);
      chk(pout[3], i[0]);
    end
    rmx <= 36'h0;
    gedge(1'b0);
    gedge(1'b1);
    chk(pout[3], 1'b0);
    term(7'd112, 36'h10, 36'h0);
    term(7'd113, 36'h8, 36'h0);
    rmx <= 36'h8;
    tick(3);
    chk(pout[3], 1'b0);
    wb(1'b1, MC3, 32'h240);
    tick(3);
    chk(pout[3], 1'b1);
    rmx <= 36'h18;
    tick(3);
    chk(pout[3], 1'b0);
    term(7'd116, 36'h220, 36'h0);
    wb(1'b1, MC4, 32'h100);
    wb(1'b1, `PLB_OFF_CTRL, 32'h10);
    oe4(36'h20, 1'b1);
    oe4(36'h0, 1'b0);
    wb(1'b1, `PLB_OFF_CTRL, 32'h0);
    oe4(36'h20, 1'b0);
    oe4(36'h220, 1'b1);
    wb(1'b1, MC4, 32'h000);
    oe4(36'h220, 1'b0);
    global_three_state_pin <= 1'b0;
    tick(10);
    chk(poe[2:0], 3'h7);
    wb(1'b1, `PLB_OFF_CTRL, 32'h40);
    tick(10);
    chk(poe, 16'h0);
    global_three_state_pin <= 1'b1;
    tick(10);
    chk(poe[2:0], 3'h7);
    pin <= 16'h8001;
    tick(8);
    chk(fb[31:16], 16'h8001);
    wb(1'b0, 8'h30, 32'h0);
    chk(q, 32'h0);
    // macrocell 5 clocked by control term two, macrocell 6 by an equation clock
    term(7'd114, 36'h40, 36'h0);
    term(7'd25, 36'h4, 36'h0);
    term(7'd30, 36'h4, 36'h0);
    wb(1'b1, `PLB_OFF_MC_BASE + 8'h14, 32'h050);
    wb(1'b1, `PLB_OFF_MC_BASE + 8'h18, 32'h044);
    wb(1'b1, `PLB_OFF_CTRL, 32'hC0);
    mcs(36'h44, 5, 1'b1);
    mcs(36'h40, 5, 1'b1);
    mcs(36'h0, 5, 1'b1);
    mcs(36'h40, 5, 1'b0);
    mcs(36'h5, 6, 1'b1);
    mcs(36'h1, 6, 1'b1);
    mcs(36'h0, 6, 1'b1);
    mcs(36'h1, 6, 1'b0);
    rmx <= 36'h3;
    tick(3);
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    tick(1);
    chk({fb, poe, pout}, 64'h0);
    close_out();
  end

  // roughly sixty times the length of the planned sequence
  initial begin
    #200000;
    fails++;
    close_out();
  end
endmodule // plb_logic_block_test
